/* File: src/pie_irq_enable.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pie_irq_enable
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   input  wire logic [3:0]        i_pstrb,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   input  wire logic              i_timer6_match_flag,
   input  wire logic              i_comparator2_flag,
   input  wire logic              i_comparator1_flag,
   input  wire logic              i_nonvolatile_done_flag,
   input  wire logic              i_timer4_match_flag,
   input  wire logic              i_oscillator_nco_flag,
   output logic                   o_core_irq,
   output logic                   o_peripheral_pending
);

   // The decoder compares against twelve-bit offsets, so elaboration stops outside that range.
   if (ADDR_W < 4 || ADDR_W > 12)
   begin : gen_bad_addr_w
      $error("pie_irq_enable needs ADDR_W between 4 and 12.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   localparam int SRC_W_L = pie_pkg::SRC_W; // Local copy for port widths.

   logic [7:0]  enable_reg;               // Stored source enables.
   logic [7:0]  enable_next;              // Next value of the enables.
   logic [7:0]  control_reg;              // Global and peripheral master enables.
   logic [7:0]  control_next;             // Next value of the master enables.
   logic [31:0] prdata_reg;               // Registered read data.
   logic [31:0] prdata_next;              // Next read data.
   logic        pready_reg;               // Registered ready, high for one cycle.
   logic        pready_next;              // Next ready.
   logic        pslverr_reg;              // Registered error answer.
   logic        pslverr_next;             // Next error answer.
   logic        core_irq_reg;             // Request toward the processor core.
   logic        core_irq_next;            // Next core request.
   logic        pending_reg;              // Any enabled source is active.
   logic        pending_next;             // Next pending level.
   logic [11:0] addr_w;                   // Address widened to the offset width.
   logic [SRC_W_L-1:0] flags_w;           // Source flags by enable position.
   logic [SRC_W_L-1:0] gated_w;           // Flags after the per-source enables.
   logic        complete_w;               // Access phase ends at this edge.
   logic        wr_lane_w;                // Write carries the register byte lane.
   logic        hit_enable_w;             // Address selects the enable register.
   logic        hit_control_w;            // Address selects the control register.
   logic        hit_status_w;             // Address selects the status register.
   logic [31:0] read_mux_w;               // Data of the addressed register.

   ////////////////////////////////////////////////////////////////////////////
   // Source collection and gating.

   // The flags are placed at the position of their enable; empty slots stay low.
   always_comb
   begin
      flags_w                         = '0;
      flags_w[pie_pkg::TIMER6_BIT]    = i_timer6_match_flag;
      flags_w[pie_pkg::COMP2_BIT]     = i_comparator2_flag;
      flags_w[pie_pkg::COMP1_BIT]     = i_comparator1_flag;
      flags_w[pie_pkg::NVM_BIT]       = i_nonvolatile_done_flag;
      flags_w[pie_pkg::TIMER4_BIT]    = i_timer4_match_flag;
      flags_w[pie_pkg::NCO_BIT]       = i_oscillator_nco_flag;
   end

   // Each request passes only while its own enable is one.
   pie_gate_bank
   #(
      .WIDTH     (SRC_W_L)
   )
   u_gate_bank
   (
      .i_flags   (flags_w),
      .i_enables (enable_reg),
      .o_gated   (gated_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB address decode.

   // The offsets are compared at their full width after zero extension.
   always_comb
   begin
      addr_w        = '0;
      addr_w[ADDR_W-1:0] = i_paddr;
      hit_enable_w  = 1'b0;
      hit_control_w = 1'b0;
      hit_status_w  = 1'b0;
      if (addr_w == pie_pkg::ENABLE_OFFSET)
      begin
         hit_enable_w = 1'b1;
      end
      else if (addr_w == pie_pkg::CONTROL_OFFSET)
      begin
         hit_control_w = 1'b1;
      end
      else if (addr_w == pie_pkg::STATUS_OFFSET)
      begin
         hit_status_w = 1'b1;
      end
   end

   // Read data of the addressed register; unused bits read as zero.
   always_comb
   begin
      read_mux_w = '0;
      if (hit_enable_w)
      begin
         read_mux_w[7:0] = enable_reg & pie_pkg::ENABLE_MASK;
      end
      else if (hit_control_w)
      begin
         read_mux_w[7:0] = control_reg;
      end
      else if (hit_status_w)
      begin
         read_mux_w[pie_pkg::STATUS_RAW_LSB +: 8]  = flags_w;
         read_mux_w[pie_pkg::STATUS_GATE_LSB +: 8] = gated_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait cycle, then ready for exactly one cycle.

   // A transfer completes at the edge where select, enable and ready are all high.
   assign complete_w = i_psel & i_penable & pready_reg;
   assign wr_lane_w  = i_pwrite & i_pstrb[pie_pkg::DATA_LANE];

   // Ready rises at the edge that ends the first access cycle; data and error rise with it.
   always_comb
   begin
      pready_next  = 1'b0;
      prdata_next  = pie_pkg::RDATA_IDLE;
      pslverr_next = 1'b0;
      if (i_psel && i_penable && !pready_reg)
      begin
         pready_next  = 1'b1;
         pslverr_next = !(hit_enable_w || hit_control_w || hit_status_w);
         if (!i_pwrite)
         begin
            prdata_next = read_mux_w;
         end
      end
   end

   // Handshake registers.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= pie_pkg::RDATA_IDLE;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers.

   // Writes land at the completing edge; masked positions never store.
   always_comb
   begin
      enable_next  = enable_reg;
      control_next = control_reg;
      if (complete_w && wr_lane_w)
      begin
         if (hit_enable_w)
         begin
            enable_next = i_pwdata[7:0] & pie_pkg::ENABLE_MASK;
         end
         else if (hit_control_w)
         begin
            control_next = i_pwdata[7:0] & pie_pkg::CONTROL_MASK;
         end
      end
   end

   // Every reset clears the enables.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         enable_reg  <= pie_pkg::ENABLE_RESET;
         control_reg <= pie_pkg::CONTROL_RESET;
      end
      else
      begin
         enable_reg  <= enable_next;
         control_reg <= control_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request toward the core.

   // Both master enables must be one for a gated request to reach the core.
   always_comb
   begin
      pending_next  = |gated_w;
      core_irq_next = pending_next
                    & control_reg[pie_pkg::PERIPH_EN_BIT]
                    & control_reg[pie_pkg::GLOBAL_EN_BIT];
   end

   // Request registers.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         core_irq_reg <= 1'b0;
         pending_reg  <= 1'b0;
      end
      else
      begin
         core_irq_reg <= core_irq_next;
         pending_reg  <= pending_next;
      end
   end

   // Outputs straight from flip-flops.
   assign o_prdata             = prdata_reg;
   assign o_pready             = pready_reg;
   assign o_pslverr            = pslverr_reg;
   assign o_core_irq           = core_irq_reg;
   assign o_peripheral_pending = pending_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb_sys @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   // Timer-6 up with its enable low and no other gate open: nothing reaches the core.
   property p_timer6_block;
      (i_timer6_match_flag && !enable_reg[pie_pkg::TIMER6_BIT] && (flags_w & enable_reg) == '0)
         |=> !o_core_irq && !o_peripheral_pending;
   endproperty
   a_timer6_block: assert property (p_timer6_block) else $error("Timer-6 request passed while disabled.");

   // Second comparator enabled with both masters set raises the core request.
   property p_comp2_pass;
      (i_comparator2_flag && enable_reg[pie_pkg::COMP2_BIT] && control_reg == pie_pkg::CONTROL_MASK)
         |=> o_core_irq;
   endproperty
   a_comp2_pass: assert property (p_comp2_pass) else $error("Comparator 2 request did not pass.");

   // First comparator up with its enable low and no other gate open leaves pending low.
   property p_comp1_block;
      (i_comparator1_flag && !enable_reg[pie_pkg::COMP1_BIT] && (flags_w & enable_reg) == '0)
         |=> !o_peripheral_pending;
   endproperty
   a_comp1_block: assert property (p_comp1_block) else $error("Comparator 1 request passed while disabled.");

   // Memory completion enabled shows pending next cycle.
   property p_nvm_pass;
      (i_nonvolatile_done_flag && enable_reg[pie_pkg::NVM_BIT]) |=> o_peripheral_pending;
   endproperty
   a_nvm_pass: assert property (p_nvm_pass) else $error("Memory completion request was lost.");

   // Unimplemented positions never hold a one and read back zero.
   property p_unimpl_zero;
      enable_reg[3:2] == 2'b00 && (!(o_pready && $past(hit_enable_w)) || o_prdata[3:2] == 2'b00);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented enable bits are not zero.");

   // Timer-4 request rises and falls with its enable gate.
   property p_timer4_gate;
      (flags_w == 8'h02) |=> o_peripheral_pending == $past(enable_reg[pie_pkg::TIMER4_BIT]);
   endproperty
   a_timer4_gate: assert property (p_timer4_gate) else $error("Timer-4 gate mismatch.");

   // A write setup followed by its access phase stores the masked byte.
   sequence s_wr_enable;
      i_psel && !i_penable && i_pwrite && hit_enable_w && i_pstrb[pie_pkg::DATA_LANE]
         ##1 (i_psel && i_penable && !pready_reg)
         ##1 (i_psel && i_penable && pready_reg && i_pwrite && hit_enable_w);
   endsequence
   property p_enable_write;
      s_wr_enable |=> enable_reg == ($past(i_pwdata[7:0]) & pie_pkg::ENABLE_MASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("Enable write did not store.");

   // After reset release the enables start at zero.
   property p_reset_clear;
      @(posedge i_sys_clk) (i_resetn && !$past(i_resetn)) |-> enable_reg == pie_pkg::ENABLE_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Enables not cleared by reset.");

   // Oscillator request enabled with both masters set reaches the core.
   property p_nco_pass;
      (i_oscillator_nco_flag && enable_reg[pie_pkg::NCO_BIT] && control_reg == pie_pkg::CONTROL_MASK)
         |=> o_core_irq;
   endproperty
   a_nco_pass: assert property (p_nco_pass) else $error("Oscillator request did not pass.");

   // Peripheral master enable low keeps the core request low.
   property p_periph_master;
      !control_reg[pie_pkg::PERIPH_EN_BIT] |=> !o_core_irq;
   endproperty
   a_periph_master: assert property (p_periph_master) else $error("Core request despite peripheral master off.");

   // Global enable low keeps the core request low for two cycles running.
   property p_global_off;
      (!control_reg[pie_pkg::GLOBAL_EN_BIT])[*2] |=> !o_core_irq && !$past(o_core_irq);
   endproperty
   a_global_off: assert property (p_global_off) else $error("Core request despite global enable off.");

endmodule

/* File: src/pie_pkg.sv */
package pie_pkg;

   // Byte offsets of the registers on the APB port.
   localparam logic [11:0] ENABLE_OFFSET   = 12'h000;
   localparam logic [11:0] CONTROL_OFFSET  = 12'h004;
   localparam logic [11:0] STATUS_OFFSET   = 12'h008;

   // Width of the enable register and of the source vector.
   localparam int          SRC_W           = 8;

   // Bit positions inside the enable register and the source vector.
   localparam int          TIMER6_BIT      = 7;
   localparam int          COMP2_BIT       = 6;
   localparam int          COMP1_BIT       = 5;
   localparam int          NVM_BIT         = 4;
   localparam int          TIMER4_BIT      = 1;
   localparam int          NCO_BIT         = 0;

   // Storage mask of the enable register; positions three and two hold nothing.
   localparam logic [7:0]  ENABLE_MASK     = 8'hF3;

   // Reset value of the enable register.
   localparam logic [7:0]  ENABLE_RESET    = 8'h00;

   // Bit positions inside the control register.
   localparam int          GLOBAL_EN_BIT   = 7;
   localparam int          PERIPH_EN_BIT   = 6;

   // Storage mask and reset value of the control register.
   localparam logic [7:0]  CONTROL_MASK    = 8'hC0;
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;

   // Field positions of the status register.
   localparam int          STATUS_RAW_LSB  = 0;
   localparam int          STATUS_GATE_LSB = 8;

   // Byte lane that carries the eight register bits.
   localparam int          DATA_LANE       = 0;

   // Value placed on the read data bus outside a read answer.
   localparam logic [31:0] RDATA_IDLE      = 32'h0000_0000;

endpackage

/* File: src/pie_gate_bank.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// One AND gate per source: a request passes only where its enable is set.
module pie_gate_bank
#(
   parameter int WIDTH = 8
)
(
   input  wire logic [WIDTH-1:0] i_flags,
   input  wire logic [WIDTH-1:0] i_enables,
   output logic      [WIDTH-1:0] o_gated
);

   // A bank of zero width cannot gate anything, so elaboration stops.
   if (WIDTH < 1)
   begin : gen_bad_width
      $error("pie_gate_bank needs WIDTH of at least one.");
   end

   // Each source is gated by the enable at its own position.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : gen_gate
         assign o_gated[g] = i_flags[g] & i_enables[g];
      end
   endgenerate

endmodule

/* File: dv/pie_src_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Far side model: the peripherals raise their request flags from the clock.
// The bench commands a vector laid out at the enable positions; the model
// registers it, as a real peripheral flag would be a flip-flop output.
module pie_src_model
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_resetn,
   input  wire logic [7:0] i_request,
   output logic            o_timer6_match_flag,
   output logic            o_comparator2_flag,
   output logic            o_comparator1_flag,
   output logic            o_nonvolatile_done_flag,
   output logic            o_timer4_match_flag,
   output logic            o_oscillator_nco_flag
);
   logic [7:0] flag_reg;  // Registered peripheral flags.
   logic [7:0] flag_next; // Next value of the flags.

   // Positions three and two have no peripheral behind them.
   always_comb
   begin
      flag_next = i_request & 8'hF3;
   end

   // Flags clear on reset like every peripheral flag.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         flag_reg <= 8'h00;
      end
      else
      begin
         flag_reg <= flag_next;
      end
   end

   assign o_timer6_match_flag     = flag_reg[7];
   assign o_comparator2_flag      = flag_reg[6];
   assign o_comparator1_flag      = flag_reg[5];
   assign o_nonvolatile_done_flag = flag_reg[4];
   assign o_timer4_match_flag     = flag_reg[1];
   assign o_oscillator_nco_flag   = flag_reg[0];
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Bench: APB register traffic plus commanded peripheral flags.
module tb_top;
   logic        sys_clk, resetn, psel, penable, pwrite;  // Clock, reset, APB controls.
   logic [11:0] paddr;                                    // APB byte address.
   logic [31:0] pwdata, prdata, rdat;                     // Write data, read data, last read.
   logic [3:0]  pstrb;                                    // Byte strobes.
   logic        pready, pslverr, core_irq, pending, rerr; // Design outputs and last error.
   logic [7:0]  request;                                  // Commanded source flags.
   logic        f_t6, f_c2, f_c1, f_nvm, f_t4, f_nco;     // Flags from the model.
   int          err_count, cmp_count;                     // Mismatch and compare counters.
   int          bits [6] = '{7, 6, 5, 4, 1, 0};           // Implemented enable positions.

   pie_irq_enable DUT (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_timer6_match_flag(f_t6), .i_comparator2_flag(f_c2),
      .i_comparator1_flag(f_c1), .i_nonvolatile_done_flag(f_nvm), .i_timer4_match_flag(f_t4),
      .i_oscillator_nco_flag(f_nco), .o_core_irq(core_irq), .o_peripheral_pending(pending));

   pie_src_model u_src (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_request(request),
      .o_timer6_match_flag(f_t6), .o_comparator2_flag(f_c2), .o_comparator1_flag(f_c1),
      .o_nonvolatile_done_flag(f_nvm), .o_timer4_match_flag(f_t4), .o_oscillator_nco_flag(f_nco));

   // The clock toggles every half period of 10 ns.
   always #10 sys_clk = ~sys_clk;

   // Compares one value and counts it.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // One APB transfer; pready is sampled at rising edges and the request is released at that same edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_count++;
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Commands the flags and waits until both registered stages have passed.
   task automatic setreq(input logic [7:0] v);
      @(posedge sys_clk);
      request <= v;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // Prints the verdict and ends the run.
   task automatic conclude();
      if (err_count == 0 && cmp_count > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      sys_clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0; request = 8'h00;
      err_count = 0; cmp_count = 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      apb(1'b0, pie_pkg::ENABLE_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_0000, "enable reset");
      apb(1'b0, pie_pkg::CONTROL_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_0000, "control reset");
      apb(1'b1, pie_pkg::ENABLE_OFFSET, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, pie_pkg::ENABLE_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_00F3, "enable readback");
      // A write without the low strobe must leave the register alone.
      apb(1'b1, pie_pkg::ENABLE_OFFSET, 32'h0, 4'h0);
      apb(1'b0, pie_pkg::ENABLE_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_00F3, "strobe off");
      apb(1'b1, pie_pkg::CONTROL_OFFSET, 32'h0000_00C0, 4'hF);
      // Each source alone: blocked with every other flag up, passed on its own.
      foreach (bits[k])
      begin
         apb(1'b1, pie_pkg::ENABLE_OFFSET, 32'h1 << bits[k], 4'hF);
         setreq(~(8'h01 << bits[k]));
         chk({30'h0, pending, core_irq}, 32'h0, "others blocked");
         apb(1'b0, pie_pkg::STATUS_OFFSET, 32'h0, 4'hF);
         chk(rdat, {24'h0, ~(8'h01 << bits[k]) & 8'hF3}, "status raw");
         setreq(8'h01 << bits[k]);
         chk({30'h0, pending, core_irq}, 32'h3, "own passed");
      end
      // Master enables: each one alone must hold the core request off.
      apb(1'b1, pie_pkg::ENABLE_OFFSET, 32'h0000_00F3, 4'hF);
      apb(1'b1, pie_pkg::CONTROL_OFFSET, 32'h0000_0080, 4'hF);
      setreq(8'hF3);
      chk({30'h0, pending, core_irq}, 32'h2, "peripheral master off");
      apb(1'b1, pie_pkg::CONTROL_OFFSET, 32'h0000_0040, 4'hF);
      setreq(8'hF3);
      chk({30'h0, pending, core_irq}, 32'h2, "global off");
      apb(1'b1, pie_pkg::CONTROL_OFFSET, 32'h0000_00C0, 4'hF);
      setreq(8'hF3);
      chk({30'h0, pending, core_irq}, 32'h3, "both on");
      apb(1'b0, pie_pkg::CONTROL_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_00C0, "control readback");
      apb(1'b0, 12'h010, 32'h0, 4'hF);
      chk({rerr, rdat[30:0]}, 32'h8000_0000, "unmapped read");
      // A second reset in mid-run clears the enables again.
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      setreq(8'hF3);
      chk({30'h0, pending, core_irq}, 32'h0, "after reset");
      apb(1'b0, pie_pkg::ENABLE_OFFSET, 32'h0, 4'hF);
      chk(rdat, 32'h0000_0000, "enable second reset");
      conclude();
   end

   // Watchdog: the sequence needs well under a thousand cycles.
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      conclude();
   end
endmodule
